// >>> rtl/lopm_exec.sv
/*
 execute stage for nor/or/immediate_disjunction, the lock-spin hold, and the
 paired_single merges merge_low_low / merge_low_high.
 assumes operand values are read from the register files upstream and arrive
 with the instruction; link_reservation_flag and the wake event come from
 the same clock domain.
*/
// What this block and its software do
// [RULE1] nor of two general_registers into dest
// [RULE2] or of two general_registers into dest
// [RULE3] immediate_disjunction: zero-extend immediate, or, write
// [RULE4] software pads delay slots with zero word
// [RULE5] spin hold decoded from shift amount five
// [RULE6] single thread: stall until flag clears or interrupt
// [RULE7] multi thread: deschedule until flag clears; the block only stalls, and wake_event_i also ends the hold
// [RULE8] remote lock write clears flag, releasing hold
// [RULE9] software keeps spin hold out of slots
// [RULE10] merge_low_low: low of a, low of b
// [RULE11] merge_low_high: low of a, high of b
// [RULE12] merges raise no float exception flags
// [RULE13] software avoids merges in sixteen-register mode
// [RULE14] merges: only unusable or reserved exceptions
// [RULE15] zero word executes as harmless shift
// [RULE16] writes to register zero are discarded
`timescale 1ns/1ps
`default_nettype none
module lopm_exec #(
	parameter bit HAS_SPIN = 1'b1,
	parameter bit HAS_PS   = 1'b1
) (
	input  wire logic                        clk_i,
	input  wire logic                        srst_i,
	input  wire logic                        ce_i,
	input  wire logic                        valid_i,
	input  wire logic [31:0]                 insn_i,
	input  wire logic [lopm_pkg::XLEN-1:0]   gsrc_a_i,
	input  wire logic [lopm_pkg::XLEN-1:0]   gsrc_b_i,
	input  wire logic [lopm_pkg::FLEN-1:0]   fsrc_a_i,
	input  wire logic [lopm_pkg::FLEN-1:0]   fsrc_b_i,
	input  wire logic                        fpu_usable_i,
	input  wire logic                        link_flag_i,
	input  wire logic                        wake_event_i,
	output logic                             stall_o,
	output lopm_pkg::lopm_gwr_t              gwr_o,
	output lopm_pkg::lopm_fwr_t              fwr_o,
	output logic                             exc_unusable_o,
	output logic                             exc_reserved_o,
	output logic                             fp_flags_o
);
	lopm_pkg::lopm_insn_t  ins;
	lopm_pkg::lopm_state_t st_r, st_nxt;
	lopm_pkg::lopm_gwr_t   gwr_nxt;
	lopm_pkg::lopm_fwr_t   fwr_nxt;
	wire logic              is_zero_op, is_nor, is_or, is_ori, is_spin, is_fp, is_ps, is_mll, is_mlh;
	wire logic              take, gdst_ok, fp_other;
	wire logic [lopm_pkg::RIDX-1:0] gdst;
	wire logic [lopm_pkg::XLEN-1:0] gres;
	wire logic [lopm_pkg::XLEN-1:0] imm_ext;

	// opcode and function code together; shared by the register-form decodes
	function automatic logic op_fn_hit(
		input lopm_pkg::lopm_insn_t w,
		input logic [5:0]           op,
		input logic [5:0]           fn
	);
		return w.op == op && w.fn == fn;
	endfunction

	assign ins        = lopm_pkg::lopm_insn_t'(insn_i);
	assign take       = valid_i && (st_r == lopm_pkg::LOPM_RUN);
	assign is_zero_op = ins.op == lopm_pkg::OP_ZERO;
	assign is_nor     = op_fn_hit(ins, lopm_pkg::OP_ZERO, lopm_pkg::FN_NOR); // RULE1
	assign is_or      = op_fn_hit(ins, lopm_pkg::OP_ZERO, lopm_pkg::FN_OR); // RULE2
	assign is_ori     = ins.op == lopm_pkg::OP_ORIMM;
	// all register fields zero, otherwise it is an ordinary shift
	assign is_spin    = HAS_SPIN && is_zero_op && ins.fn == lopm_pkg::FN_SHL
		&& ins.ra == lopm_pkg::R_ZERO && ins.rb == lopm_pkg::R_ZERO
		&& ins.rd == lopm_pkg::R_ZERO && ins.sa == lopm_pkg::SA_SPIN; // RULE5
	assign is_fp      = ins.op == lopm_pkg::OP_FPCOP;
	// format field shares the source_a slot of the carrier
	assign is_ps      = is_fp && ins.ra == lopm_pkg::FMT_PS;
	assign is_mll     = is_ps && op_fn_hit(ins, lopm_pkg::OP_FPCOP, lopm_pkg::FN_MLL); // RULE10
	assign is_mlh     = is_ps && op_fn_hit(ins, lopm_pkg::OP_FPCOP, lopm_pkg::FN_MLH); // RULE11
	assign fp_other   = is_mll || is_mlh;
	assign imm_ext    = {{(lopm_pkg::XLEN - lopm_pkg::IMM_W){1'b0}}, insn_i[lopm_pkg::IMM_W-1:0]};
	assign gdst       = is_ori ? ins.rb : ins.rd;
	assign gres       = is_nor ? ~(gsrc_a_i | gsrc_b_i) : // RULE1
		is_ori ? (gsrc_a_i | imm_ext) : (gsrc_a_i | gsrc_b_i); // RULE3 RULE2
	// zero word (shift of r0 by 0) falls through with no write at all
	assign gdst_ok    = gdst != lopm_pkg::R_ZERO; // RULE16 RULE15

	always_comb begin
		gwr_nxt      = '0;
		gwr_nxt.en   = take && (is_nor || is_or || is_ori) && gdst_ok; // RULE16
		gwr_nxt.idx  = gdst;
		gwr_nxt.data = gres;
		fwr_nxt      = '0;
		fwr_nxt.en   = take && HAS_PS && fp_other && fpu_usable_i; // RULE14
		fwr_nxt.idx  = ins.sa;
		fwr_nxt.data = is_mlh ? {fsrc_a_i[lopm_pkg::SGL_W-1:0],
			fsrc_b_i[lopm_pkg::FLEN-1:lopm_pkg::SGL_W]} : // RULE11
			{fsrc_a_i[lopm_pkg::SGL_W-1:0], fsrc_b_i[lopm_pkg::SGL_W-1:0]}; // RULE10
	end

	// one waiter per instance; a threaded core instances one per thread
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			lopm_pkg::LOPM_RUN: begin
				if (take && is_spin && link_flag_i) begin
					st_nxt = lopm_pkg::LOPM_HOLD; // RULE6 RULE7
				end
			end
			lopm_pkg::LOPM_HOLD: begin
				if (!link_flag_i || wake_event_i) begin
					st_nxt = lopm_pkg::LOPM_RUN; // RULE6 RULE7 RULE8
				end
			end
			default: st_nxt = lopm_pkg::LOPM_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r           <= lopm_pkg::LOPM_RUN;
			stall_o        <= 1'b0;
			gwr_o          <= '0;
			fwr_o          <= '0;
			exc_unusable_o <= 1'b0;
			exc_reserved_o <= 1'b0;
			fp_flags_o     <= 1'b0;
		end else if (ce_i) begin
			st_r           <= st_nxt;
			stall_o        <= st_nxt == lopm_pkg::LOPM_HOLD;
			gwr_o          <= gwr_nxt;
			fwr_o          <= fwr_nxt;
			exc_unusable_o <= take && fp_other && !fpu_usable_i; // RULE14
			// unusable outranks reserved, so only one cause is reported
			exc_reserved_o <= take && fp_other && fpu_usable_i && !HAS_PS; // RULE14
			fp_flags_o     <= 1'b0; // RULE12
		end
	end

	property p_nor;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_nor && gdst_ok |=> gwr_o.en
			&& gwr_o.data == ~($past(gsrc_a_i) | $past(gsrc_b_i));
	endproperty
	a_nor: assert property (p_nor) else $error("nor result wrong"); // RULE1
	property p_or;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_or && gdst_ok |=> gwr_o.data == ($past(gsrc_a_i) | $past(gsrc_b_i));
	endproperty
	a_or: assert property (p_or) else $error("or result wrong"); // RULE2
	property p_ori;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_ori && gdst_ok |=> gwr_o.en && gwr_o.idx == $past(ins.rb)
			&& gwr_o.data == ($past(gsrc_a_i) | {{(lopm_pkg::XLEN - lopm_pkg::IMM_W){1'b0}},
			$past(insn_i[lopm_pkg::IMM_W-1:0])});
	endproperty
	a_ori: assert property (p_ori) else $error("immediate or wrong"); // RULE3
	property p_hold;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_spin && link_flag_i |=> stall_o;
	endproperty
	a_hold: assert property (p_hold) else $error("spin did not hold"); // RULE6
	property p_release;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && st_r == lopm_pkg::LOPM_HOLD && !link_flag_i |=> !stall_o;
	endproperty
	a_release: assert property (p_release) else $error("hold not released"); // RULE8
	property p_mll;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_mll && HAS_PS && fpu_usable_i |=> fwr_o.en && fwr_o.idx == $past(ins.sa)
			&& fwr_o.data == {$past(fsrc_a_i[lopm_pkg::SGL_W-1:0]),
			$past(fsrc_b_i[lopm_pkg::SGL_W-1:0])};
	endproperty
	a_mll: assert property (p_mll) else $error("low merge wrong"); // RULE10
	property p_mlh;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_mlh && HAS_PS && fpu_usable_i |=> fwr_o.en && fwr_o.idx == $past(ins.sa)
			&& fwr_o.data == {$past(fsrc_a_i[lopm_pkg::SGL_W-1:0]),
			$past(fsrc_b_i[lopm_pkg::FLEN-1:lopm_pkg::SGL_W])};
	endproperty
	a_mlh: assert property (p_mlh) else $error("high merge wrong"); // RULE11
	property p_noflag;
		@(posedge clk_i) disable iff (srst_i)
		!fp_flags_o;
	endproperty
	a_noflag: assert property (p_noflag) else $error("fp flag raised"); // RULE12
	property p_r0;
		@(posedge clk_i) disable iff (srst_i)
		gwr_o.en |-> gwr_o.idx != lopm_pkg::R_ZERO;
	endproperty
	a_r0: assert property (p_r0) else $error("write to zero register"); // RULE16
	property p_unusable;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && fp_other && !fpu_usable_i
			|=> exc_unusable_o && !exc_reserved_o && !fwr_o.en;
	endproperty
	a_unusable: assert property (p_unusable) else $error("unusable exception missed"); // RULE14
	property p_noexc;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && (is_nor || is_or || is_ori || is_spin)
			|=> !exc_unusable_o && !exc_reserved_o;
	endproperty
	a_noexc: assert property (p_noexc) else $error("logic op raised exception"); // RULE14
	property p_nop;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && insn_i == '0 |=> !gwr_o.en && !fwr_o.en && !stall_o;
	endproperty
	a_nop: assert property (p_nop) else $error("zero word had an effect"); // RULE15
	property p_fmt;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_fp && !is_ps |=> !fwr_o.en;
	endproperty
	a_fmt: assert property (p_fmt) else $error("merge taken with wrong format"); // RULE10
	property p_wake;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && st_r == lopm_pkg::LOPM_HOLD && wake_event_i |=> !stall_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not release"); // RULE6
	property p_free;
		@(posedge clk_i) disable iff (srst_i)
		ce_i && take && is_spin && !link_flag_i |=> !stall_o;
	endproperty
	a_free: assert property (p_free) else $error("spin stalled on clear flag"); // RULE5
endmodule
`default_nettype wire

// >>> rtl/lopm_pkg.sv
/*
 logic-op, spin-hold and paired-single merge definitions: opcodes, field
 positions, packed carriers. assumes a 32-bit instruction word.
*/
package lopm_pkg;
	localparam int unsigned XLEN  = 32;
	localparam int unsigned FLEN  = 64;
	localparam int unsigned RIDX  = 5;
	localparam int unsigned IMM_W = 16;
	localparam int unsigned SGL_W = 32;

	localparam logic [5:0] OP_ZERO  = 6'h00;
	localparam logic [5:0] OP_ORIMM = 6'h0d;
	localparam logic [5:0] OP_FPCOP = 6'h11;
	localparam logic [5:0] FN_SHL   = 6'h00;
	localparam logic [5:0] FN_OR    = 6'h25;
	localparam logic [5:0] FN_NOR   = 6'h27;
	localparam logic [5:0] FN_MLL   = 6'h2c;
	localparam logic [5:0] FN_MLH   = 6'h2d;
	localparam logic [4:0] FMT_PS   = 5'h16;
	localparam logic [4:0] SA_SPIN  = 5'h05;
	localparam logic [4:0] R_ZERO   = 5'h00;

	typedef struct packed {
		logic [5:0] op;
		logic [4:0] ra;
		logic [4:0] rb;
		logic [4:0] rd;
		logic [4:0] sa;
		logic [5:0] fn;
	} lopm_insn_t;

	typedef struct packed {
		logic            en;
		logic [RIDX-1:0] idx;
		logic [XLEN-1:0] data;
	} lopm_gwr_t;

	typedef struct packed {
		logic            en;
		logic [RIDX-1:0] idx;
		logic [FLEN-1:0] data;
	} lopm_fwr_t;

	typedef enum logic [1:0] {
		LOPM_RUN  = 2'h0,
		LOPM_HOLD = 2'h1
	} lopm_state_t;
endpackage

// >>> tb/lopm_peer.sv
/*
 issue-side model of the link_reservation_flag for one thread.
 assumes the same clock as the execute stage.
*/
`timescale 1ns/1ps
`default_nettype none
module lopm_peer (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ll_i,
	input  wire logic remote_wr_i,
	output logic      link_flag_o
);
	// remote store wins over a same-cycle load_linked
	always_ff @(posedge clk_i) begin
		if (srst_i || remote_wr_i) begin
			link_flag_o <= 1'b0;
		end else if (ll_i) begin
			link_flag_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 self-checking bench for lopm_exec with the link flag model.
 assumes one-cycle registered answers and a single thread.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                clk_i = 1'b0, srst_i = 1'b1, valid_i = 1'b0, fpu = 1'b1, ce = 1'b1;
	logic                wake = 1'b0, ll = 1'b0, rwr = 1'b0, link, stall, exu, exr, fpf;
	logic [31:0]         insn_i = 32'h0, ga = 32'h0, gb = 32'h0;
	logic [63:0]         fa = 64'h0, fb = 64'h0;
	lopm_pkg::lopm_gwr_t gwr;
	lopm_pkg::lopm_fwr_t fwr;
	int                  fail_count = 0, checks = 0;

	lopm_exec u_lopm_exec (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .valid_i(valid_i),
		.insn_i(insn_i), .gsrc_a_i(ga), .gsrc_b_i(gb), .fsrc_a_i(fa), .fsrc_b_i(fb),
		.fpu_usable_i(fpu), .link_flag_i(link), .wake_event_i(wake), .stall_o(stall),
		.gwr_o(gwr), .fwr_o(fwr), .exc_unusable_o(exu), .exc_reserved_o(exr),
		.fp_flags_o(fpf));
	lopm_peer u_lopm_peer (.clk_i(clk_i), .srst_i(srst_i), .ll_i(ll), .remote_wr_i(rwr),
		.link_flag_o(link));

	always #25 clk_i = ~clk_i;

	task check(input logic [69:0] seen, input logic [69:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] rw(logic [5:0] op, logic [4:0] a, logic [4:0] b,
		logic [4:0] d, logic [4:0] s, logic [5:0] fn);
		return {op, a, b, d, s, fn};
	endfunction

	// one-cycle valid, then look half a cycle after the answering edge
	task issue(input logic [31:0] w);
		@(posedge clk_i);
		insn_i <= w;
		valid_i <= 1'b1;
		@(posedge clk_i);
		valid_i <= 1'b0;
		@(negedge clk_i);
	endtask

	task t_logic;
		@(negedge clk_i);
		check({gwr.en, fwr.en, stall, exu, exr, fpf}, 70'h0);
		@(posedge clk_i);
		ga <= 32'h0f0f_1234;
		gb <= 32'h00ff_0001;
		issue(rw(lopm_pkg::OP_ZERO, 5'h01, 5'h02, 5'h03, 5'h00, lopm_pkg::FN_NOR));
		check(gwr, {1'b1, 5'h03, ~(ga | gb)});
		issue(rw(lopm_pkg::OP_ZERO, 5'h01, 5'h02, 5'h04, 5'h00, lopm_pkg::FN_OR));
		check(gwr, {1'b1, 5'h04, ga | gb});
		issue({lopm_pkg::OP_ORIMM, 5'h01, 5'h07, 16'h8001});
		check(gwr, {1'b1, 5'h07, ga | 32'h0000_8001});
		issue(rw(lopm_pkg::OP_ZERO, 5'h01, 5'h02, 5'h00, 5'h00, lopm_pkg::FN_OR));
		check(gwr.en, 70'h0);
		issue(32'h0);
		check({gwr.en, fwr.en, stall, exu, exr}, 70'h0);
		// enable low: the taken edge must leave every output alone
		@(posedge clk_i);
		ce <= 1'b0;
		issue(rw(lopm_pkg::OP_ZERO, 5'h01, 5'h02, 5'h05, 5'h00, lopm_pkg::FN_OR));
		check(gwr.en, 70'h0);
		@(posedge clk_i);
		ce <= 1'b1;
	endtask

	task t_merge;
		@(posedge clk_i);
		fa <= 64'h1111_2222_3333_4444;
		fb <= 64'h5555_6666_7777_8888;
		issue(rw(lopm_pkg::OP_FPCOP, lopm_pkg::FMT_PS, 5'h02, 5'h03, 5'h04, lopm_pkg::FN_MLL));
		check(fwr, {1'b1, 5'h04, 32'h3333_4444, 32'h7777_8888});
		check({fpf, exu, exr}, 70'h0);
		issue(rw(lopm_pkg::OP_FPCOP, lopm_pkg::FMT_PS, 5'h02, 5'h03, 5'h04, lopm_pkg::FN_MLH));
		check(fwr, {1'b1, 5'h04, 32'h3333_4444, 32'h5555_6666});
		issue(rw(lopm_pkg::OP_FPCOP, 5'h10, 5'h02, 5'h03, 5'h04, lopm_pkg::FN_MLL));
		check({fwr.en, exu, exr}, 70'h0);
		@(posedge clk_i);
		fpu <= 1'b0;
		issue(rw(lopm_pkg::OP_FPCOP, lopm_pkg::FMT_PS, 5'h02, 5'h03, 5'h04, lopm_pkg::FN_MLL));
		check({fwr.en, exu, exr, fpf}, 70'h4);
		@(posedge clk_i);
		fpu <= 1'b1;
	endtask

	// spin hold released first by a remote store, then by a wake event
	task t_spin;
		@(posedge clk_i);
		ll <= 1'b1;
		@(posedge clk_i);
		ll <= 1'b0;
		issue(rw(lopm_pkg::OP_ZERO, 5'h00, 5'h00, 5'h00, lopm_pkg::SA_SPIN, lopm_pkg::FN_SHL));
		check(stall, 70'h1);
		repeat (3) @(posedge clk_i);
		rwr <= 1'b1;
		@(negedge clk_i);
		check(stall, 70'h1);
		@(posedge clk_i);
		rwr <= 1'b0;
		@(negedge clk_i);
		check({link, stall}, 70'h1);
		@(posedge clk_i);
		@(negedge clk_i);
		check(stall, 70'h0);
		issue(rw(lopm_pkg::OP_ZERO, 5'h00, 5'h00, 5'h00, lopm_pkg::SA_SPIN, lopm_pkg::FN_SHL));
		check(stall, 70'h0);
		@(posedge clk_i);
		ll <= 1'b1;
		@(posedge clk_i);
		ll <= 1'b0;
		issue(rw(lopm_pkg::OP_ZERO, 5'h00, 5'h00, 5'h00, lopm_pkg::SA_SPIN, lopm_pkg::FN_SHL));
		check(stall, 70'h1);
		@(posedge clk_i);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		@(negedge clk_i);
		check(stall, 70'h0);
	endtask

	task test_done;
		if (fail_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		t_logic();
		t_merge();
		t_spin();
		test_done();
	end

	// about 50 cycles of tests; generous margin
	initial begin
		#20000;
		fail_count++;
		test_done();
	end
endmodule
`default_nettype wire
